// File: rtl/osc_ctrl.sv
// Oscillator control register with APB access and clock-switch sequencing.
// Assumes a clock generator that follows sel_source while switch_busy is
// high and answers with a level on switch_ack; strap, status and ack pins are asynchronous.
//
// Summary of operation
// - Read-only field reports active oscillator source.
// - Requested source field writable, loaded from straps.
// - Lock bit follows PLL lock status.
// - Freeze with switch config one refuses source, switch and freeze changes.
// - Secondary oscillator enable bit, resets low.
// - Initial source from straps, default fast RC.
`timescale 1ns/1ps
module osc_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [osc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [osc_ctrl_pkg::DATA_W-1:0] pwdata,
    output logic [osc_ctrl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Nonvolatile configuration straps
    input wire osc_ctrl_pkg::src_t initial_source_config,
    input wire logic switch_config_bit,
    // Clock system status
    input wire logic pll_lock_in,
    input wire logic clock_fail_in,
    // Clock generator handshake
    output osc_ctrl_pkg::src_t sel_source,
    output logic switch_busy,
    input wire logic switch_ack,
    // Secondary oscillator control
    output logic secondary_osc_enable
);
    import osc_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum {ST_IDLE, ST_SWITCH, ST_RELEASE} sw_state_e;

    sw_state_e sw_state_r;
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    src_t cfg_src;
    logic cfg_switch_cfg;
    logic pll_lock_s;
    logic fail_s;
    logic ack_s;
    logic fail_prev_r;
    logic [1:0] settle_r;
    logic cfg_loaded_r;
    logic load_cfg;
    src_t cur_src_r;
    src_t req_src_r;
    src_t target_r;
    logic freeze_r;
    logic pll_lock_r;
    logic fail_flag_r;
    logic sec_en_r;
    logic switch_req_r;
    logic busy_r;
    logic [DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic addr_hit;
    logic wr_en;
    logic frozen;
    logic switch_done;
    logic switch_drop;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Reserved codes in a software request must never reach the clock multiplexer; strap codes load unchecked.
    function automatic logic src_valid(input src_t s);
        src_valid = (s != SRC_RSVD0) && (s != SRC_RSVD6);
    endfunction

    // Assembles the visible register word; unimplemented bits read zero.
    function automatic logic [DATA_W-1:0] reg_word(
        input src_t cur,
        input src_t req,
        input logic frz,
        input logic lck,
        input logic fail,
        input logic sec,
        input logic sw
    );
        logic [DATA_W-1:0] w;
        w = '0;
        w[CUR_SRC_LSB +: 3] = cur;
        w[REQ_SRC_LSB +: 3] = req;
        w[FREEZE_BIT] = frz;
        w[PLL_LOCK_BIT] = lck;
        w[FAIL_BIT] = fail;
        w[SEC_EN_BIT] = sec;
        w[SWITCH_BIT] = sw;
        reg_word = w;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    assign pins_async = {initial_source_config, switch_config_bit, pll_lock_in,
                         clock_fail_in, switch_ack};

    sync_bank #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    assign cfg_src = pins_sync[6:4];
    assign cfg_switch_cfg = pins_sync[3];
    assign pll_lock_s = pins_sync[2];
    assign fail_s = pins_sync[1];
    assign ack_s = pins_sync[0];

    // ------------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------------
    // Straps are caught by the clock, not by the reset, after the
    // synchronisers have filled; until then the reset default stands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_r <= '0;
            cfg_loaded_r <= 1'b0;
        end else if (!cfg_loaded_r) begin
            if (settle_r == CFG_SETTLE_CYCLES) begin
                cfg_loaded_r <= 1'b1;
            end else begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    assign load_cfg = !cfg_loaded_r && (settle_r == CFG_SETTLE_CYCLES);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign addr_hit = (paddr == OSC_CTRL_OFFSET);
    assign wr_en = psel && penable && pready_r && pwrite && addr_hit;
    // Changes to source selection are locked out while frozen on a part
    // strapped to forbid switching.
    assign frozen = freeze_r && cfg_switch_cfg;

    // One wait state: pready rises on the second access cycle, so every
    // output of the slave can come straight from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !addr_hit;
            if (psel && penable && !pready_r && !pwrite && addr_hit) begin
                prdata_r <= reg_word(cur_src_r, req_src_r, freeze_r, pll_lock_r,
                                     fail_flag_r, sec_en_r, switch_req_r);
            end else if (!(psel && penable)) begin
                prdata_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Requested source field
    // ------------------------------------------------------------------
    // Writes are ignored while frozen and while a switch is pending, so
    // the field never disagrees with the target the sequencer latched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_src_r <= SRC_RESET;
        end else if (load_cfg) begin
            req_src_r <= cfg_src;
        end else if (wr_en && !frozen && !switch_req_r) begin
            req_src_r <= pwdata[REQ_SRC_LSB +: 3];
        end
    end

    // ------------------------------------------------------------------
    // Freeze bit
    // ------------------------------------------------------------------
    // Once frozen on a locked part, software cannot unfreeze; only reset or a low switch_config_bit can.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_r <= FREEZE_RESET;
        end else if (wr_en && !frozen) begin
            freeze_r <= pwdata[FREEZE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Secondary oscillator enable
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_en_r <= SEC_EN_RESET;
        end else if (wr_en) begin
            sec_en_r <= pwdata[SEC_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // PLL lock status
    // ------------------------------------------------------------------
    // The generator holds the lock input low when the PLL is disabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_lock_r <= 1'b0;
        end else begin
            pll_lock_r <= pll_lock_s;
        end
    end

    // ------------------------------------------------------------------
    // Clock fail flag
    // ------------------------------------------------------------------
    // Set on a rising fail indication, cleared by writing zero; a new
    // failure in the clearing cycle wins so no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_prev_r <= 1'b0;
            fail_flag_r <= FAIL_RESET;
        end else begin
            fail_prev_r <= fail_s;
            if (fail_s && !fail_prev_r) begin
                fail_flag_r <= 1'b1;
            end else if (wr_en && !pwdata[FAIL_BIT]) begin
                fail_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Switch request bit
    // ------------------------------------------------------------------
    // Software can only set the request; hardware clears it at the end of
    // the switch, or at once if the target code is reserved.
    assign switch_done = (sw_state_r == ST_SWITCH) && ack_s;
    assign switch_drop = (sw_state_r == ST_IDLE) && switch_req_r && cfg_loaded_r
                         && !src_valid(req_src_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_req_r <= SWITCH_RESET;
        end else if (switch_done || switch_drop) begin
            switch_req_r <= 1'b0;
        end else if (wr_en && !frozen && pwdata[SWITCH_BIT]) begin
            switch_req_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    // Four-phase handshake with the generator: busy up, ack up, busy down,
    // ack down. Waiting for ack low keeps back-to-back switches apart.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_state_r <= ST_IDLE;
            busy_r <= 1'b0;
            target_r <= SRC_RESET;
        end else begin
            unique case (sw_state_r)
                ST_IDLE: begin
                    if (load_cfg) begin
                        target_r <= cfg_src;
                    end else if (switch_req_r && cfg_loaded_r && src_valid(req_src_r)) begin
                        target_r <= req_src_r;
                        busy_r <= 1'b1;
                        sw_state_r <= ST_SWITCH;
                    end
                end
                ST_SWITCH: begin
                    if (ack_s) begin
                        busy_r <= 1'b0;
                        sw_state_r <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (!ack_s) begin
                        sw_state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Current source field
    // ------------------------------------------------------------------
    // Follows the target once the generator confirms the change; after reset the straps load it directly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_src_r <= SRC_RESET;
        end else if (load_cfg) begin
            cur_src_r <= cfg_src;
        end else if (switch_done) begin
            cur_src_r <= target_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sel_source = target_r;
    assign switch_busy = busy_r;
    assign secondary_osc_enable = sec_en_r;

endmodule

// File: rtl/osc_ctrl_pkg.sv
// Constants and types shared by the oscillator control register block.
// Assumes a 32-bit APB register bus and a 100 MHz register clock.
package osc_ctrl_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [2:0] src_t;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OSC_CTRL_OFFSET = 12'h000;
    localparam int REG_W = 16;

    // ------------------------------------------------------------------
    // Field positions inside oscillator_control
    // ------------------------------------------------------------------
    localparam int CUR_SRC_LSB = 12;
    localparam int REQ_SRC_LSB = 8;
    localparam int FREEZE_BIT = 7;
    localparam int PLL_LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SEC_EN_BIT = 1;
    localparam int SWITCH_BIT = 0;

    // ------------------------------------------------------------------
    // Source encodings
    // ------------------------------------------------------------------
    localparam src_t SRC_RSVD0 = 3'h0;
    localparam src_t SRC_FAST_RC_PLL = 3'h1;
    localparam src_t SRC_PRIMARY = 3'h2;
    localparam src_t SRC_PRIMARY_PLL = 3'h3;
    localparam src_t SRC_SECONDARY = 3'h4;
    localparam src_t SRC_SLOW_RC = 3'h5;
    localparam src_t SRC_RSVD6 = 3'h6;
    localparam src_t SRC_FAST_RC = 3'h7;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam src_t SRC_RESET = SRC_FAST_RC;
    localparam logic FREEZE_RESET = 1'b0;
    localparam logic SEC_EN_RESET = 1'b0;
    localparam logic SWITCH_RESET = 1'b0;
    localparam logic FAIL_RESET = 1'b0;
    // Cycles after reset release before the synchronised straps are trusted.
    localparam logic [1:0] CFG_SETTLE_CYCLES = 2'h3;
    localparam int SYNC_W = 7;

endpackage

// File: rtl/sync_bank.sv
// Bank of two-flop synchronisers for pins that arrive from outside pclk.
// Assumes each bit is an independent level; no multi-bit coherence is given.
`timescale 1ns/1ps
module sync_bank #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Two-stage capture
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    // The first stage feeds only the second, so metastability cannot spread.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule

// File: tb/osc_ctrl_checker.sv
// Port-level assertions for the oscillator control register.
// Assumes a bind onto osc_ctrl; every check runs on pclk.
`timescale 1ns/1ps
module osc_ctrl_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [osc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [osc_ctrl_pkg::DATA_W-1:0] pwdata,
    input wire logic [osc_ctrl_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Clock system
    input wire osc_ctrl_pkg::src_t initial_source_config,
    input wire logic pll_lock_in,
    input wire osc_ctrl_pkg::src_t sel_source,
    input wire logic switch_busy,
    input wire logic switch_ack,
    input wire logic secondary_osc_enable
);
    import osc_ctrl_pkg::*;
    logic [2:0] steady_r;
    // Counts quiet cycles of the lock input, because the status bit lags it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steady_r <= 3'h0;
        end else if ($changed(pll_lock_in)) begin
            steady_r <= 3'h0;
        end else if (steady_r != 3'h7) begin
            steady_r <= steady_r + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr_done;
        pready && pwrite && !pslverr;
    endsequence
    sequence s_rd_done;
        pready && !pwrite && !pslverr;
    endsequence
    sequence s_ack_seen;
        $rose(switch_ack) && switch_busy;
    endsequence
    property p_sec;
        s_wr_done |=> secondary_osc_enable == $past(pwdata[SEC_EN_BIT]);
    endproperty
    a_sec: assert property (p_sec) else $error("enable differs from write");
    property p_lock;
        s_rd_done and steady_r == 3'h7 |-> prdata[PLL_LOCK_BIT] == pll_lock_in;
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit wrong");
    property p_cur;
        s_rd_done and !switch_busy |-> prdata[14:12] == sel_source;
    endproperty
    a_cur: assert property (p_cur) else $error("current field wrong");
    property p_hold;
        switch_busy && !switch_ack |=> switch_busy;
    endproperty
    a_hold: assert property (p_hold) else $error("busy dropped early");
    property p_done;
        s_ack_seen |-> ##[2:4] !switch_busy;
    endproperty
    a_done: assert property (p_done) else $error("busy stuck after ack");
    property p_sel;
        switch_busy && $past(switch_busy) |-> $stable(sel_source);
    endproperty
    a_sel: assert property (p_sel) else $error("target moved");
    property p_strap;
        $rose(presetn) |-> ##[3:6] sel_source == initial_source_config;
    endproperty
    a_strap: assert property (p_strap) else $error("straps not loaded");
    property p_wait;
        psel && !penable |-> ##2 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("no bus answer");
    property p_err;
        pready |-> pslverr == (paddr != OSC_CTRL_OFFSET);
    endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
endmodule
bind osc_ctrl osc_ctrl_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .initial_source_config, .pll_lock_in,
    .sel_source, .switch_busy, .switch_ack, .secondary_osc_enable);

// File: tb/osc_ctrl_test.sv
// Self-checking bench for the oscillator control register.
// Assumes osc_ctrl and its bound checker are compiled first.
`timescale 1ns/1ps
module osc_ctrl_test;
    import osc_ctrl_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rnd;
    logic pready, pslverr, switch_busy, secondary_osc_enable, switch_ack = 1'b0;
    logic switch_config_bit = 1'b0, pll_lock_in = 1'b0, clock_fail_in = 1'b0;
    src_t straps = SRC_PRIMARY, sel_source, cur = SRC_PRIMARY, req = SRC_PRIMARY;
    logic frz = 1'b0, lk = 1'b0, sec = 1'b0, cf = 1'b0;
    logic [31:0] exp_q[$], msk_q[$];
    logic err_q[$];
    int n_errors = 0, checked = 0, seed = 82;
    osc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .initial_source_config(straps), .switch_config_bit(switch_config_bit),
        .pll_lock_in(pll_lock_in), .clock_fail_in(clock_fail_in), .sel_source(sel_source),
        .switch_busy(switch_busy), .switch_ack(switch_ack),
        .secondary_osc_enable(secondary_osc_enable));
    // Free-running register clock.
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checked++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got & m, exp & m);
        end
    endtask
    task automatic to_out();
        n_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask
    // Compares each completed transfer with the oldest note in the queues.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk(prdata, exp_q.pop_front(), msk_q.pop_front());
            chk({31'h0, pslverr}, {31'h0, err_q.pop_front()}, 32'h1);
        end
    end
    // The model word mirrors the register layout; unused bits read as zero.
    function automatic logic [31:0] exp_word();
        return {17'h0, cur, 1'b0, req, frz, 1'b0, lk, 1'b0, cf, 1'b0, sec, 1'b0};
    endfunction
    // Random filler lands on read-only and unused bits, which must not matter.
    function automatic logic [31:0] wd(input src_t r, input logic f, input logic s,
                                       input logic go);
        rnd = $random(seed);
        return (rnd & 32'hFFFF_F874) | {21'h0, r, f, 5'h0, s, go};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic er);
        int n;
        n = 0;
        exp_q.push_back(e);
        msk_q.push_back(m);
        err_q.push_back(er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) to_out();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd();
        apb(1'b0, OSC_CTRL_OFFSET, 32'h0, exp_word(), 32'hFFFF_FFFF, 1'b0);
    endtask
    task automatic wr(input logic [31:0] d);
        apb(1'b1, OSC_CTRL_OFFSET, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (switch_busy !== v && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) to_out();
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        rd();
        chk({29'h0, sel_source}, {29'h0, SRC_PRIMARY}, 32'h7);
        $display("test reset done");
        sec = 1'b1;
        wr(wd(req, 1'b0, sec, 1'b0));
        chk({31'h0, secondary_osc_enable}, {31'h0, sec}, 32'h1);
        lk = 1'b1;
        pll_lock_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rd();
        $display("test enable and lock done");
        // Every code in turn; the two reserved ones must be dropped.
        for (int i = 0; i < 8; i++) begin
            req = src_t'(i);
            wr(wd(req, 1'b0, sec, 1'b0));
            wr(wd(req, 1'b0, sec, 1'b1));
            if (req == SRC_RSVD0 || req == SRC_RSVD6) begin
                repeat (4) @(posedge pclk);
                chk({31'h0, switch_busy}, 32'h0, 32'h1);
            end else begin
                wait_busy(1'b1);
                chk({29'h0, sel_source}, {29'h0, req}, 32'h7);
                switch_ack <= 1'b1;
                wait_busy(1'b0);
                switch_ack <= 1'b0;
                cur = req;
                repeat (4) @(posedge pclk);
            end
            rd();
        end
        $display("test switch done");
        switch_config_bit <= 1'b1;
        repeat (4) @(posedge pclk);
        frz = 1'b1;
        wr(wd(req, 1'b1, sec, 1'b0));
        wr(wd(SRC_PRIMARY, 1'b0, sec, 1'b1));
        repeat (4) @(posedge pclk);
        chk({31'h0, switch_busy}, 32'h0, 32'h1);
        rd();
        switch_config_bit <= 1'b0;
        lk = 1'b0;
        pll_lock_in <= 1'b0;
        repeat (4) @(posedge pclk);
        frz = 1'b0;
        req = SRC_PRIMARY;
        wr(wd(req, 1'b0, sec, 1'b0));
        rd();
        $display("test freeze done");
        apb(1'b0, 12'h004, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
        apb(1'b1, 12'h004, wd(SRC_SLOW_RC, 1'b1, 1'b0, 1'b1), 32'h0, 32'h0, 1'b1);
        rd();
        $display("test unmapped done");
        // A rising fail level sets the flag; a written one must not clear it.
        cf = 1'b1;
        clock_fail_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rd();
        wr(wd(req, 1'b0, sec, 1'b0) | 32'h0000_0008);
        rd();
        cf = 1'b0;
        wr(wd(req, 1'b0, sec, 1'b0));
        clock_fail_in <= 1'b0;
        rd();
        $display("test fail flag done");
        // A second power-on with other straps must reload both source fields.
        presetn <= 1'b0;
        straps <= SRC_SECONDARY;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cur = SRC_SECONDARY;
        req = SRC_SECONDARY;
        sec = 1'b0;
        repeat (8) @(posedge pclk);
        rd();
        chk({29'h0, sel_source}, {29'h0, SRC_SECONDARY}, 32'h7);
        $display("test second reset done");
        print_verdict();
    end
endmodule
